// >>> verilog/decode_pkg.sv
/*
 Package for the paged address decode block: address windows, page
 numbers, space-map bit positions and the bus-side carrier types.
 Assumes a 16-bit core address and an 8-bit page register.
*/
package decode_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned PAGE_W = 8;
   localparam int unsigned MAIN_SEGS = 8;
   localparam int unsigned BOOT_SEGS = 4;
   localparam int unsigned PAGE_BITS_MAX = 4;

   // Main flash: 32K segment per page in upper memory
   localparam logic [15:0] MAIN_LO = 16'h8000;
   localparam logic [15:0] MAIN_HI = 16'hffff;
   // Boot flash: four 8K segments in lower memory, page independent
   localparam logic [15:0] BOOT_BASE = 16'h0000;
   localparam logic [15:0] BOOT_SPAN = 16'h2000;
   // SRAM 8K in data space
   localparam logic [15:0] SRAM_LO = 16'h2000;
   localparam logic [15:0] SRAM_HI = 16'h3fff;
   // I/O register block, 256 bytes in data space
   localparam logic [15:0] IOREG_LO = 16'h4000;
   localparam logic [15:0] IOREG_HI = 16'h40ff;
   // Repeater windows and display window
   localparam logic [15:0] REP0_LO = 16'h0300;
   localparam logic [15:0] REP0_HI = 16'h03ff;
   localparam logic [15:0] REP1_LO = 16'h0400;
   localparam logic [15:0] REP1_HI = 16'h04ff;
   localparam logic [15:0] DISP_LO = 16'h0300;
   localparam logic [15:0] DISP_HI = 16'h03ff;

   // Space-map register layout and power-up value
   localparam int unsigned MAP_MAIN_CODE = 0;
   localparam int unsigned MAP_MAIN_DATA = 1;
   localparam int unsigned MAP_BOOT_CODE = 2;
   localparam int unsigned MAP_BOOT_DATA = 3;
   localparam logic [3:0]  MAP_RESET     = 4'h6;
   localparam logic [7:0]  PAGE_RESET    = 8'h00;

   typedef struct packed {
      logic [15:0] addr;
      logic        rd_n;
      logic        wr_n;
      logic        fetch_n;
      logic        latch;
   } core_bus_t;

   typedef struct packed {
      logic [7:0] main_sel;
      logic [3:0] boot_sel;
      logic       sram_sel;
      logic       ioreg_sel;
   } mem_sel_t;

endpackage

// >>> verilog/paged_memory_decode.sv
/*
 Paged address decode: turns the core address, strobes, page register
 and space-map register into per-segment memory selects, a data-bus
 repeater on an external port and two display glue outputs.
 Assumes the core bus inputs are synchronous to clk; the port pins of
 the repeater come from outside and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module paged_memory_decode #(
   parameter int unsigned PAGE_BITS = 3
) (
   input  wire logic                  clk,          // 20 MHz core clock
   input  wire logic                  rst,          // Sync reset, high
   input  wire decode_pkg::core_bus_t bus_in,       // Core addr/strobes
   input  wire logic [7:0]            core_data_out, // Core write data
   input  wire logic                  peripheral_io_mode, // Port A mode
   input  wire logic                  page_wr,      // Page reg write
   input  wire logic [7:0]            page_wdata,   // Page reg data
   input  wire logic                  map_wr,       // Space-map write
   input  wire logic [3:0]            map_wdata,    // Space-map data
   input  wire logic [7:0]            port_in,      // Port pins in
   output logic [7:0]                 port_out,     // Port pins out
   output logic [7:0]                 port_oe_n,    // Port drive, low on
   output logic [7:0]                 core_data_in, // Data to core
   output logic                       core_data_drive, // Core bus drive
   output decode_pkg::mem_sel_t       mem_sel,      // Internal selects
   output logic [3:0]                 space_map_register, // Map readback
   output logic [3:0]                 page_bits,    // Paging bits
   output logic [3:0]                 spare_page_register_bits, // Spare
   output logic                       display_strobe, // Display enable
   output logic                       display_read_write // Display r/w
);

   ////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] page_reg;
   logic [3:0] map_reg;
   logic [7:0] port_meta_reg;
   logic [7:0] port_sync_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         page_reg <= decode_pkg::PAGE_RESET;
         map_reg  <= decode_pkg::MAP_RESET;
      end else begin
         if (page_wr) begin
            page_reg <= page_wdata;
         end
         if (map_wr) begin
            map_reg <= map_wdata;
         end
      end
   end

   // Pins are asynchronous to the core; two stages before use
   always_ff @(posedge clk) begin
      if (rst) begin
         port_meta_reg <= 8'h00;
         port_sync_reg <= 8'h00;
      end else begin
         port_meta_reg <= port_in;
         port_sync_reg <= port_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Only the low PAGE_BITS of the page register take part
   function automatic logic page_match(input logic [7:0] pg,
                                       input logic [3:0] num);
      logic [3:0] mask;
      mask = 4'((5'h01 << PAGE_BITS) - 5'h01);
      page_match = ((pg[3:0] & mask) == (num & mask));
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Space qualification

   wire [15:0] a = bus_in.addr;
   wire data_acc = !bus_in.rd_n || !bus_in.wr_n;
   wire code_acc = !bus_in.fetch_n;
   // Fixed qualification: latch phase carries address, never data
   wire strobe_ok = !bus_in.latch;

   wire main_in_data = map_reg[decode_pkg::MAP_MAIN_DATA];
   wire main_in_code = map_reg[decode_pkg::MAP_MAIN_CODE];
   wire boot_in_data = map_reg[decode_pkg::MAP_BOOT_DATA];
   wire boot_in_code = map_reg[decode_pkg::MAP_BOOT_CODE];

   wire main_space = strobe_ok && ((main_in_data && data_acc)
                     || (main_in_code && code_acc));
   wire boot_space = strobe_ok && ((boot_in_code && code_acc)
                     || (boot_in_data && data_acc));
   wire data_space = strobe_ok && data_acc;

   ////////////////////////////////////////////////////////////////////
   // Segment selects

   wire main_win = in_range(a, decode_pkg::MAIN_LO, decode_pkg::MAIN_HI);
   logic [7:0] main_sel_w;
   logic [3:0] boot_sel_w;

   genvar gi;
   generate
      for (gi = 0; gi < decode_pkg::MAIN_SEGS; gi++) begin : g_main
         assign main_sel_w[gi] = main_space && main_win
                   && page_match(page_reg, 4'(gi));
      end
      for (gi = 0; gi < decode_pkg::BOOT_SEGS; gi++) begin : g_boot
         localparam logic [15:0] LO =
            16'(decode_pkg::BOOT_BASE + gi * decode_pkg::BOOT_SPAN);
         localparam logic [15:0] HI =
            16'(LO + decode_pkg::BOOT_SPAN - 16'h0001);
         assign boot_sel_w[gi] = boot_space && in_range(a, LO, HI);
      end
   endgenerate

   wire sram_sel_w = data_space
        && in_range(a, decode_pkg::SRAM_LO, decode_pkg::SRAM_HI);
   wire ioreg_sel_w = data_space
        && in_range(a, decode_pkg::IOREG_LO, decode_pkg::IOREG_HI);

   ////////////////////////////////////////////////////////////////////
   // Repeater and display glue

   wire rep_sel0 = in_range(a, decode_pkg::REP0_LO, decode_pkg::REP0_HI);
   wire rep_sel1 = in_range(a, decode_pkg::REP1_LO, decode_pkg::REP1_HI);
   wire rep_on = peripheral_io_mode && (rep_sel0 || rep_sel1);
   wire rep_write = rep_on && !bus_in.wr_n;
   wire rep_read = rep_on && !bus_in.rd_n && bus_in.wr_n;
   // External select: strobes written out explicitly
   wire disp_w = in_range(a, decode_pkg::DISP_LO, decode_pkg::DISP_HI)
                 && (!bus_in.rd_n || !bus_in.wr_n);

   ////////////////////////////////////////////////////////////////////
   // Output registers; one cycle behind the bus, traded for clean edges

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_sel            <= '0;
         port_out           <= 8'h00;
         port_oe_n          <= 8'hff;
         core_data_in       <= 8'h00;
         core_data_drive    <= 1'b0;
         display_strobe     <= 1'b0;
         display_read_write <= 1'b0;
      end else begin
         mem_sel.main_sel   <= main_sel_w;
         mem_sel.boot_sel   <= boot_sel_w;
         mem_sel.sram_sel   <= sram_sel_w;
         mem_sel.ioreg_sel  <= ioreg_sel_w;
         port_out           <= core_data_out;
         port_oe_n          <= {8{!rep_write}};
         core_data_in       <= port_sync_reg;
         core_data_drive    <= rep_read;
         display_strobe     <= disp_w;
         display_read_write <= a[0];
      end
   end

   assign space_map_register       = map_reg;
   assign page_bits                = page_reg[3:0];
   assign spare_page_register_bits = page_reg[7:4];

endmodule

`default_nettype wire

// >>> sim/decode_chk.sv
/* Port checker for paged_memory_decode, bound to every instance.
   Assumes one clock domain and the synchronous reset rst. */
`timescale 1ns/1ps
`default_nettype none
module decode_chk (
   input wire logic                  clk,                // Clock
   input wire logic                  rst,                // Reset
   input wire decode_pkg::core_bus_t bus_in,             // Core bus
   input wire logic                  peripheral_io_mode, // Repeater mode
   input wire logic [7:0]            port_oe_n,          // Port drive
   input wire logic                  core_data_drive,    // Core drive
   input wire decode_pkg::mem_sel_t  mem_sel,            // Selects
   input wire logic [3:0]            space_map_register, // Map
   input wire logic [3:0]            page_bits,          // Page bits
   input wire logic                  display_strobe,     // Display enable
   input wire logic                  display_read_write  // Display r/w
);
   wire logic disp_w = bus_in.addr >= 16'h0300 && bus_in.addr <= 16'h03ff;
   wire logic rep_w  = peripheral_io_mode && bus_in.addr >= 16'h0300
                       && bus_in.addr <= 16'h04ff;
   wire logic data_w = !bus_in.rd_n || !bus_in.wr_n;
   wire logic go_w   = !bus_in.latch;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   disp_strobe_a: assert property (display_strobe == $past(disp_w && data_w))
      else $error("display strobe mismatch");
   disp_rw_a: assert property (display_read_write == $past(bus_in.addr[0]))
      else $error("display rw mismatch");
   rep_dir_a: assert property (port_oe_n == ($past(rep_w && !bus_in.wr_n) ? 8'h00 : 8'hff))
      else $error("port drive mismatch");
   rep_read_a: assert property (core_data_drive == $past(rep_w && !bus_in.rd_n))
      else $error("core drive mismatch");
   main_page_a: assert property ($past(bus_in.addr[15] && go_w && data_w && space_map_register[1]) |-> mem_sel.main_sel == 8'h01 << $past(page_bits[2:0]))
      else $error("main select mismatch");
   boot_seg_a: assert property ($past(!bus_in.addr[15] && go_w && !bus_in.fetch_n && space_map_register[2]) |-> mem_sel.boot_sel == 4'h1 << $past(bus_in.addr[14:13]))
      else $error("boot select mismatch");
   sram_sel_a: assert property (mem_sel.sram_sel == $past(go_w && data_w && bus_in.addr[15:13] == 3'h1))
      else $error("sram select mismatch");
   ioreg_sel_a: assert property (mem_sel.ioreg_sel == $past(go_w && data_w && bus_in.addr[15:8] == 8'h40))
      else $error("io select mismatch");
   latch_block_a: assert property ($past(bus_in.latch) |-> mem_sel == '0)
      else $error("select during latch");
   map_reset_a: assert property (disable iff (1'b0) $past(rst) && rst |-> space_map_register == 4'h6)
      else $error("map not restored");
   cover property ($past(rep_w && !bus_in.wr_n));
   cover property ($past(bus_in.latch));
   cover property (mem_sel.main_sel[7]);
endmodule
bind paged_memory_decode decode_chk i_chk (.clk(clk), .rst(rst),
   .bus_in(bus_in), .peripheral_io_mode(peripheral_io_mode),
   .port_oe_n(port_oe_n), .core_data_drive(core_data_drive),
   .mem_sel(mem_sel), .space_map_register(space_map_register),
   .page_bits(page_bits), .display_strobe(display_strobe),
   .display_read_write(display_read_write));
`default_nettype wire

// >>> sim/core_model.sv
/* Core-side bus model: issues one strobe cycle at a time.
   Assumes the caller waits for the task to return before the next. */
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic             clk,  // Core clock
   output decode_pkg::core_bus_t bus,  // Address and strobes
   output logic [7:0]            dout  // Write data
);
   initial begin
      bus = '{16'h0000, 1'b1, 1'b1, 1'b1, 1'b0};
      dout = 8'h00;
   end
   task automatic cyc(input decode_pkg::core_bus_t b, input logic [7:0] d);
      @(posedge clk);
      bus <= b;
      dout <= d;
      @(posedge clk);
      bus <= '{b.addr, 1'b1, 1'b1, 1'b1, 1'b0};
      dout <= ~d; // Released data must not look held
   endtask
endmodule
`default_nettype wire

// >>> sim/paged_memory_decode_tb.sv
/* Self-checking bench for paged_memory_decode.
   Assumes core_model drives the bus and decode_chk is bound. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module paged_memory_decode_tb;
   logic                  clk, rst, mode, page_wr, map_wr, cdrv, dstb, drw;
   logic [7:0]            page_wdata, port_in, port_out, oe_n, cdin, dout;
   logic [3:0]            map_wdata, map_q, pg, spare;
   decode_pkg::core_bus_t bus;
   decode_pkg::mem_sel_t  sel;
   int                    num_errors = 0;
   int                    checked = 0;
   core_model i_core (.clk(clk), .bus(bus), .dout(dout));
   paged_memory_decode #(.PAGE_BITS(3)) i_dut (.clk(clk), .rst(rst),
      .bus_in(bus), .core_data_out(dout), .peripheral_io_mode(mode),
      .page_wr(page_wr), .page_wdata(page_wdata), .map_wr(map_wr),
      .map_wdata(map_wdata), .port_in(port_in), .port_out(port_out),
      .port_oe_n(oe_n), .core_data_in(cdin), .core_data_drive(cdrv),
      .mem_sel(sel), .space_map_register(map_q), .page_bits(pg),
      .spare_page_register_bits(spare), .display_strobe(dstb),
      .display_read_write(drw));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   // k: bit0 read, bit1 write, bit2 fetch
   task automatic go(input logic [15:0] a, input logic [2:0] k);
      i_core.cyc('{a, !k[0], !k[1], !k[2], 1'b0}, a[7:0]);
      #1;
   endtask
   task automatic wreg(input logic pw, input logic [7:0] d);
      @(posedge clk);
      page_wr <= pw;
      map_wr <= !pw;
      page_wdata <= d;
      map_wdata <= d[3:0];
      @(posedge clk);
      page_wr <= 1'b0;
      map_wr <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_main;
      for (int p = 0; p < 8; p++) begin
         wreg(1'b1, {4'ha, 4'(p)});
         go(16'hffff - 16'(p), 3'h1);
         `CHK(sel.main_sel, 8'h01 << p)
         `CHK(spare, 4'ha)
         `CHK(pg, 4'(p))
      end
      $display("test main done");
   endtask
   task automatic t_boot;
      for (int s = 0; s < 4; s++) begin
         go(16'(s) * 16'h2000 + 16'h1fff, 3'h4);
         `CHK(sel.boot_sel, 4'h1 << s)
         `CHK(sel.sram_sel, 1'b0)
      end
      go(16'h0000, 3'h1);
      `CHK(sel.boot_sel, 4'h0)
      $display("test boot done");
   endtask
   task automatic t_data;
      wreg(1'b1, 8'h05);
      go(16'h3fff, 3'h2);
      `CHK(sel.sram_sel, 1'b1)
      go(16'h40ff, 3'h1);
      `CHK(sel.ioreg_sel, 1'b1)
      go(16'h4100, 3'h1);
      `CHK(sel.ioreg_sel, 1'b0)
      i_core.cyc('{16'h2000, 1'b0, 1'b1, 1'b1, 1'b1}, 8'h00);
      #1;
      `CHK(sel, 14'h0000)
      $display("test data done");
   endtask
   task automatic t_remap;
      wreg(1'b0, 8'h01);
      go(16'h8000, 3'h4);
      `CHK(sel.main_sel, 8'h20)
      go(16'h8000, 3'h1);
      `CHK(sel.main_sel, 8'h00)
      wreg(1'b0, 8'h08);
      go(16'h0000, 3'h1);
      `CHK(sel.boot_sel, 4'h1)
      go(16'h0000, 3'h4);
      `CHK(sel.boot_sel, 4'h0)
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK(map_q, 4'h6)
      `CHK(pg, 4'h0)
      @(posedge clk) rst <= 1'b0;
      $display("test remap done");
   endtask
   task automatic t_rep;
      @(posedge clk) mode <= 1'b1;
      go(16'h0302, 3'h2);
      `CHK(oe_n, 8'h00)
      `CHK(port_out, 8'h02)
      `CHK({dstb, drw}, 2'h2)
      go(16'h0401, 3'h1);
      `CHK({cdrv, oe_n, cdin}, 17'h1ff3c)
      `CHK(dstb, 1'b0)
      @(posedge clk) mode <= 1'b0;
      go(16'h0303, 3'h2);
      `CHK({oe_n, dstb, drw}, 10'h3ff)
      $display("test repeater done");
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
   initial begin
      {rst, mode, page_wr, map_wr, page_wdata, map_wdata} = 16'h8000;
      port_in = 8'h3c;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK({map_q, pg, oe_n}, 16'h60ff)
      t_main();
      t_boot();
      t_data();
      t_remap();
      t_rep();
      give_verdict();
   end
endmodule
`default_nettype wire
